// >>> adcts_top.v
// Converter timing, input multiplexer select and scan sequencing block
//
// Our own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "adcts_consts.vh"

module adcts_top #(
  parameter NUM_PINS = 13
) (
  input  wire        core_clk,
  input  wire        sys_rst,
  input  wire [4:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  input  wire        rc_clk_in,
  input  wire        sample_start,
  input  wire        sample_done,
  output wire        conv_tick,
  output reg         sampling,
  output reg         convert_start,
  output reg  [3:0]  pos_in_sel,
  output reg         neg_in_sel,
  output reg         pos_in_lowref,
  output reg  [2:0]  trigger_source_sel,
  output reg         alternate_sample_en,
  output reg         scan_enable
);

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  reg [31:0] clk_cfg_reg;
  reg [31:0] mux_sel_reg;
  reg [31:0] scan_map_reg;
  reg        use_b_reg;
  reg [3:0]  scan_idx_reg;
  reg        scan_armed_reg;
  reg [4:0]  samp_cnt_reg;
  reg        start_meta_reg;
  reg        start_sync_reg;
  reg        start_prev_reg;
  reg        done_meta_reg;
  reg        done_sync_reg;
  reg        done_prev_reg;

  wire       conv_clk_src_sel;
  wire [4:0] auto_sample_time;
  wire [7:0] conv_clk_divider;
  wire       neg_in_sel_a;
  wire       neg_in_sel_b;
  wire [3:0] pos_in_sel_a;
  wire [3:0] pos_in_sel_b;
  wire [15:0] scan_map;
  wire       start_pulse;
  wire       done_pulse;
  wire       auto_mode;

  assign conv_clk_src_sel = clk_cfg_reg[`ADCTS_CLK_SRC_BIT];
  assign auto_sample_time = clk_cfg_reg[`ADCTS_SMPT_MSB:`ADCTS_SMPT_LSB];
  assign conv_clk_divider = clk_cfg_reg[`ADCTS_DIV_MSB:`ADCTS_DIV_LSB];
  assign neg_in_sel_b     = mux_sel_reg[`ADCTS_NEG_B_BIT];
  assign pos_in_sel_b     = mux_sel_reg[`ADCTS_POS_B_MSB:`ADCTS_POS_B_LSB];
  assign neg_in_sel_a     = mux_sel_reg[`ADCTS_NEG_A_BIT];
  assign pos_in_sel_a     = mux_sel_reg[`ADCTS_POS_A_MSB:`ADCTS_POS_A_LSB];
  assign scan_map         = scan_map_reg[15:0];
  assign auto_mode        = (trigger_source_sel == `ADCTS_TRIG_AUTO);  // R4

  // --------------------------------------------------------------------------
  // Conversion clock
  // --------------------------------------------------------------------------
  adcts_clk_div u_clk_div (
    .core_clk  (core_clk),
    .sys_rst   (sys_rst),
    .src_rc    (conv_clk_src_sel),
    .divider   (conv_clk_divider),
    .rc_clk_in (rc_clk_in),
    .conv_tick (conv_tick)
  );

  // --------------------------------------------------------------------------
  // Register writes
  // --------------------------------------------------------------------------
  always @(posedge core_clk) begin
    if (sys_rst) begin
      clk_cfg_reg         <= `ADCTS_RST_CLK_CFG;
      mux_sel_reg         <= `ADCTS_RST_MUX_SEL;
      scan_map_reg        <= `ADCTS_RST_SCAN_MAP;
      trigger_source_sel  <= 3'h0;
      alternate_sample_en <= 1'b0;
      scan_enable         <= 1'b0;
    end else if (reg_wr) begin
      case (reg_addr)
        `ADCTS_OFF_CLK_CFG: begin
          clk_cfg_reg <= reg_wdata & `ADCTS_MASK_CLK_CFG;  // R14
        end
        `ADCTS_OFF_MUX_SEL: begin
          mux_sel_reg <= reg_wdata & `ADCTS_MASK_MUX_SEL;  // R14
        end
        `ADCTS_OFF_SCAN_MAP: begin
          scan_map_reg <= reg_wdata & `ADCTS_MASK_SCAN_MAP;  // R14
        end
        `ADCTS_OFF_CTRL: begin
          trigger_source_sel  <= reg_wdata[`ADCTS_CTRL_TRIG_MSB:`ADCTS_CTRL_TRIG_LSB];
          alternate_sample_en <= reg_wdata[`ADCTS_CTRL_ALT_BIT];
          scan_enable         <= reg_wdata[`ADCTS_CTRL_SCAN_BIT];
        end
        default: begin
          clk_cfg_reg <= clk_cfg_reg;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Register reads, one cycle after the strobe
  // --------------------------------------------------------------------------
  always @(posedge core_clk) begin
    if (sys_rst) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        `ADCTS_OFF_CLK_CFG:  reg_rdata <= clk_cfg_reg;
        `ADCTS_OFF_MUX_SEL:  reg_rdata <= mux_sel_reg;
        `ADCTS_OFF_SCAN_MAP: reg_rdata <= scan_map_reg;
        `ADCTS_OFF_CTRL:     reg_rdata <= {27'h0000000, scan_enable, alternate_sample_en, trigger_source_sel};
        `ADCTS_OFF_STATUS:   reg_rdata <= {22'h000000, sampling, use_b_reg, scan_idx_reg, 4'h0};
        default:             reg_rdata <= 32'h00000000;
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

  // --------------------------------------------------------------------------
  // Sequence inputs from the converter core, synchronised
  // --------------------------------------------------------------------------
  always @(posedge core_clk) begin
    if (sys_rst) begin
      start_meta_reg <= 1'b0;
      start_sync_reg <= 1'b0;
      start_prev_reg <= 1'b0;
      done_meta_reg  <= 1'b0;
      done_sync_reg  <= 1'b0;
      done_prev_reg  <= 1'b0;
    end else begin
      start_meta_reg <= sample_start;
      start_sync_reg <= start_meta_reg;
      start_prev_reg <= start_sync_reg;
      done_meta_reg  <= sample_done;
      done_sync_reg  <= done_meta_reg;
      done_prev_reg  <= done_sync_reg;
    end
  end

  assign start_pulse = start_sync_reg & ~start_prev_reg;
  assign done_pulse  = done_sync_reg & ~done_prev_reg;

  // --------------------------------------------------------------------------
  // Auto-sample counter
  // --------------------------------------------------------------------------
  always @(posedge core_clk) begin
    if (sys_rst) begin
      sampling      <= 1'b0;
      samp_cnt_reg  <= 5'h00;
      convert_start <= 1'b0;
    end else begin
      convert_start <= 1'b0;
      if (start_pulse && !sampling) begin
        sampling     <= 1'b1;
        samp_cnt_reg <= 5'h00;
      end else if (sampling && auto_mode && conv_tick) begin  // R17
        // A zero time is illegal; treat it as one period so sampling still ends
        if (samp_cnt_reg + 5'h01 >= auto_sample_time) begin  // R2
          sampling      <= 1'b0;
          convert_start <= 1'b1;
          samp_cnt_reg  <= 5'h00;
        end else begin
          samp_cnt_reg <= samp_cnt_reg + 5'h01;
        end
      end else if (sampling && !auto_mode && done_pulse) begin
        // Other trigger sources end sampling from outside
        sampling <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Alternate and scan sequencing, advanced at each sample's end
  // --------------------------------------------------------------------------
  reg [3:0] next_idx;
  reg       found;
  reg [4:0] k;
  reg [3:0] cand;

  always @* begin
    next_idx = scan_idx_reg;
    found    = 1'b0;
    cand     = 4'h0;
    // Ascending search with wrap; an empty map leaves the index alone
    for (k = 5'd1; k <= 5'd16; k = k + 5'd1) begin
      cand = scan_idx_reg + k[3:0];
      if (!found && scan_map[cand]) begin  // R10 R18
        next_idx = cand;
        found    = 1'b1;
      end
    end
  end

  wire seq_step;
  assign seq_step = convert_start | (done_pulse & !auto_mode);

  always @(posedge core_clk) begin
    if (sys_rst) begin
      use_b_reg      <= 1'b0;
      scan_idx_reg   <= 4'hf;
      scan_armed_reg <= 1'b0;
    end else begin
      if (!alternate_sample_en) begin
        use_b_reg <= 1'b0;  // R15
      end else if (seq_step) begin
        use_b_reg <= ~use_b_reg;  // R15
      end
      if (!scan_enable) begin
        scan_idx_reg   <= 4'hf;
        scan_armed_reg <= 1'b0;
      end else if (!scan_armed_reg && !sampling) begin
        // The rest index would stick when bit 15 is set; the first pick is the lowest set bit
        scan_idx_reg   <= next_idx;  // R18
        scan_armed_reg <= 1'b1;
      end else if (seq_step || (!scan_map[scan_idx_reg] && !sampling)) begin
        scan_idx_reg <= next_idx;  // R18
      end
    end
  end

  // --------------------------------------------------------------------------
  // Multiplexer outputs
  // --------------------------------------------------------------------------
  always @(posedge core_clk) begin
    if (sys_rst) begin
      pos_in_sel    <= 4'h0;
      neg_in_sel    <= `ADCTS_NEG_LOWREF;
      pos_in_lowref <= 1'b0;
    end else begin
      if (use_b_reg) begin
        neg_in_sel <= neg_in_sel_b;  // R6
        pos_in_sel <= pos_in_sel_b;  // R7
      end else begin
        neg_in_sel <= neg_in_sel_a;  // R8
        pos_in_sel <= scan_enable ? scan_idx_reg : pos_in_sel_a;  // R9 R16 R11
      end
      // A scanned analog input with no pin on this package converts the low reference
      pos_in_lowref <= scan_enable && !use_b_reg && (scan_idx_reg < 4'hd)
                       && ({1'b0, scan_idx_reg} >= NUM_PINS[4:0]);  // R12
    end
  end

endmodule // adcts_top
`default_nettype wire

// >>> adcts_consts.vh
// Constants for the converter timing and input-select block
//
// Function
// R1 - Clock source bit 15 set picks internal RC oscillator, clear picks bus clock.
// R2 - Five-bit auto-sample time counts 1 to 31 conversion clock periods; zero not allowed.
// R3 - Bus-clocked conversion period is bus period times 2 times (divider plus one).
// R4 - Auto-sample time applies only when trigger source is the auto-convert code.
// R5 - Divider field is ignored while the internal RC oscillator is chosen.
// R6 - Setting B negative select bit 31 picks analog input 1, else low reference.
// R7 - Setting B positive select: inputs 0-12, then temperature sensor, reference, open.
// R8 - Setting A negative select bit 23 picks analog input 1, else low reference.
// R9 - Setting A positive select uses the same code mapping as setting B.
// R10 - Each scan map bit includes its input when set, skips it when clear.
// R11 - Scan bits 0-12 are inputs; 13 charge-time unit, 14 reference, 15 ground.
// R12 - Scan bits without a physical pin convert the low reference.
// R13 - Software picks the open input code only for charge-time measurements.
// R14 - Unimplemented bits read zero and ignore writes.
// R15 - Alternate off always uses A; on uses A first, then B and A alternately.
// R16 - Scan enable takes the positive input from the scan map instead of A.
// R17 - Auto-convert trigger: internal counter ends sampling after the auto-sample time.
// R18 - Scan steps ascending through selected inputs, wrapping to the lowest one.
`ifndef ADCTS_CONSTS_VH
`define ADCTS_CONSTS_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define ADCTS_OFF_CLK_CFG      5'h00
`define ADCTS_OFF_MUX_SEL      5'h04
`define ADCTS_OFF_SCAN_MAP     5'h08
`define ADCTS_OFF_CTRL         5'h0c
`define ADCTS_OFF_STATUS       5'h10

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define ADCTS_CLK_SRC_BIT      15
`define ADCTS_SMPT_MSB         12
`define ADCTS_SMPT_LSB         8
`define ADCTS_DIV_MSB          7
`define ADCTS_DIV_LSB          0
`define ADCTS_NEG_B_BIT        31
`define ADCTS_POS_B_MSB        27
`define ADCTS_POS_B_LSB        24
`define ADCTS_NEG_A_BIT        23
`define ADCTS_POS_A_MSB        19
`define ADCTS_POS_A_LSB        16
`define ADCTS_CTRL_TRIG_MSB    2
`define ADCTS_CTRL_TRIG_LSB    0
`define ADCTS_CTRL_ALT_BIT     3
`define ADCTS_CTRL_SCAN_BIT    4
`define ADCTS_CTRL_SAMP_BIT    5

// ----------------------------------------------------------------------------
// Write masks and reset values
// ----------------------------------------------------------------------------
`define ADCTS_MASK_CLK_CFG     32'h00009fff
`define ADCTS_MASK_MUX_SEL     32'h8f8f0000
`define ADCTS_MASK_SCAN_MAP    32'h0000ffff
`define ADCTS_MASK_CTRL        32'h0000001f
`define ADCTS_RST_CLK_CFG      32'h00000000
`define ADCTS_RST_MUX_SEL      32'h00000000
`define ADCTS_RST_SCAN_MAP     32'h00000000
`define ADCTS_RST_CTRL         32'h00000000

// ----------------------------------------------------------------------------
// Codes
// ----------------------------------------------------------------------------
`define ADCTS_TRIG_AUTO        3'h7
`define ADCTS_POS_TEMP         4'hd
`define ADCTS_POS_IREF         4'he
`define ADCTS_POS_OPEN         4'hf
`define ADCTS_NEG_LOWREF       1'b0
`define ADCTS_NEG_INPUT1       1'b1
`define ADCTS_SCAN_CHARGE_BIT  13
`define ADCTS_SCAN_IREF_BIT    14
`define ADCTS_SCAN_GND_BIT     15

`endif

// >>> adcts_clk_div.v
// Conversion clock tick generator: bus clock divider or synchronised RC clock edges
`timescale 1ns/1ps
`default_nettype none
`include "adcts_consts.vh"

module adcts_clk_div (
  input  wire       core_clk,
  input  wire       sys_rst,
  input  wire       src_rc,
  input  wire [7:0] divider,
  input  wire       rc_clk_in,
  output reg        conv_tick
);

  reg [8:0] cnt_reg;
  reg       rc_meta_reg;
  reg       rc_sync_reg;
  reg       rc_prev_reg;
  wire [8:0] terminal;

  // Half period is divider+1 bus clocks, so a full period is 2*(divider+1)
  assign terminal = {divider, 1'b1};  // R3

  always @(posedge core_clk) begin
    if (sys_rst) begin
      rc_meta_reg <= 1'b0;
      rc_sync_reg <= 1'b0;
      rc_prev_reg <= 1'b0;
    end else begin
      rc_meta_reg <= rc_clk_in;
      rc_sync_reg <= rc_meta_reg;
      rc_prev_reg <= rc_sync_reg;
    end
  end

  always @(posedge core_clk) begin
    if (sys_rst) begin
      cnt_reg   <= 9'h000;
      conv_tick <= 1'b0;
    end else if (src_rc) begin  // R1
      // Divider is not looked at on the RC source
      cnt_reg   <= 9'h000;  // R5
      // A source switch must not give two ticks in a row
      conv_tick <= rc_sync_reg & ~rc_prev_reg & ~conv_tick;
    end else if (cnt_reg >= terminal) begin
      cnt_reg   <= 9'h000;  // R3
      conv_tick <= 1'b1;
    end else begin
      cnt_reg   <= cnt_reg + 9'h001;
      conv_tick <= 1'b0;
    end
  end

endmodule // adcts_clk_div
`default_nettype wire

// >>> adcts_monitor.sv
// Assertion checker bound to the converter timing and input-select top
`timescale 1ns/1ps
`default_nettype none
module adcts_monitor #(
  parameter NUM_PINS = 13
) (
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic [4:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        conv_tick,
  input wire logic        sampling,
  input wire logic        convert_start,
  input wire logic [3:0]  pos_in_sel,
  input wire logic        pos_in_lowref,
  input wire logic [2:0]  trigger_source_sel
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside an answer");
  AST_CLK_MASK: assert property ($past(reg_rd) && $past(reg_addr) == 5'h0 |-> (reg_rdata & 32'hffff6000) == 32'h0)
    else $error("clock config unused bits not zero");
  AST_MUX_MASK: assert property ($past(reg_rd) && $past(reg_addr) == 5'h4 |-> (reg_rdata & 32'h7070ffff) == 32'h0)
    else $error("mux select unused bits not zero");
  AST_UNMAPPED: assert property ($past(reg_rd) && $past(reg_addr) > 5'h10 |-> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  AST_SCAN_WR: assert property (reg_wr && reg_addr == 5'h8 ##1 reg_rd && reg_addr == 5'h8
    |=> reg_rdata == ($past(reg_wdata, 2) & 32'h0000ffff))
    else $error("scan map readback wrong");
  AST_TICK_GAP: assert property (conv_tick |=> !conv_tick)
    else $error("tick period below two cycles");
  AST_CONV_PULSE: assert property (convert_start |=> !convert_start)
    else $error("convert start longer than one cycle");
  AST_CONV_ENDS: assert property (convert_start |-> !sampling && $past(sampling))
    else $error("convert start without end of sampling");
  AST_CONV_AUTO: assert property (convert_start |-> trigger_source_sel == 3'h7)
    else $error("convert start outside auto trigger");
  AST_LOWREF: assert property (pos_in_lowref |-> pos_in_sel >= NUM_PINS && pos_in_sel <= 4'hc)
    else $error("low reference flag on a present input");
endmodule // adcts_monitor

bind adcts_top adcts_monitor #(.NUM_PINS(NUM_PINS)) i_adcts_monitor (
  .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_tick(conv_tick),
  .sampling(sampling), .convert_start(convert_start), .pos_in_sel(pos_in_sel),
  .pos_in_lowref(pos_in_lowref), .trigger_source_sel(trigger_source_sel));
`default_nettype wire

// >>> adcts_core_model.sv
// Model of the converter core and RC oscillator beside the block
`timescale 1ns/1ps
`default_nettype none
module adcts_core_model (
  input  wire logic       core_clk,
  input  wire logic       go,
  input  wire logic [7:0] hold_cyc,
  output var  logic       sample_start,
  output var  logic       sample_done,
  output var  logic       rc_clk_in
);
  int cnt;
  // RC oscillator runs free, 120 ns, phase unrelated to the bus clock
  initial begin
    rc_clk_in = 1'b0;
    sample_start = 1'b0;
    sample_done = 1'b0;
    cnt = -1;
    #7;
    forever #60 rc_clk_in = ~rc_clk_in;
  end
  // Start level held long enough that the end-of-sample edge is seen
  always @(posedge core_clk) begin
    if (go) begin
      sample_start <= 1'b1;
      cnt <= 0;
    end else if (cnt >= 0) begin
      cnt <= cnt + 1;
      if (cnt == hold_cyc)
        sample_done <= 1'b1;
      if (cnt == hold_cyc + 4) begin
        sample_start <= 1'b0;
        sample_done <= 1'b0;
        cnt <= -1;
      end
    end
  end
endmodule // adcts_core_model
`default_nettype wire

// >>> adcts_top_test.sv
// Self-checking bench for the converter timing and input-select block
`timescale 1ns/1ps
`default_nettype none
module adcts_top_test;
  localparam int PINS = 10;
  logic        core_clk, sys_rst, reg_wr, reg_rd, go, rd_q, samp_q, conv_tick, sampling;
  logic        convert_start, neg_in_sel, pos_in_lowref, alternate_sample_en, scan_enable;
  logic        sample_start, sample_done, rc_clk_in;
  logic [4:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, m, mk[4];
  logic [7:0]  hold_cyc;
  logic [3:0]  pos_in_sel;
  logic [2:0]  trigger_source_sel;
  logic [31:0] exp_rd[$], exp_sel[$];
  int          failures = 0, checked = 0, cyc = 0, slen = 0, convs = 0, n, s, d, q[$];

  adcts_top #(.NUM_PINS(PINS)) i_adcts_top (
    .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rc_clk_in(rc_clk_in),
    .sample_start(sample_start), .sample_done(sample_done), .conv_tick(conv_tick),
    .sampling(sampling), .convert_start(convert_start), .pos_in_sel(pos_in_sel),
    .neg_in_sel(neg_in_sel), .pos_in_lowref(pos_in_lowref),
    .trigger_source_sel(trigger_source_sel), .alternate_sample_en(alternate_sample_en),
    .scan_enable(scan_enable));
  adcts_core_model i_adcts_core_model (
    .core_clk(core_clk), .go(go), .hold_cyc(hold_cyc), .sample_start(sample_start),
    .sample_done(sample_done), .rc_clk_in(rc_clk_in));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // --------
  // Tasks
  // --------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic report_and_stop;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // A read notes its expected word; both strobes set each call so none is assigned twice
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] v);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= v;
    if (!w) exp_rd.push_back(v);
    @(posedge core_clk);
  endtask
  task automatic idle;
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic smp(input logic [7:0] h, input logic [31:0] e);
    exp_sel.push_back(e);
    go <= 1'b1;
    hold_cyc <= h;
    @(posedge core_clk);
    go <= 1'b0;
    repeat (h + 10) @(posedge core_clk);
  endtask
  task automatic tick_gap(output int g);
    g = 0;
    do @(posedge core_clk); while (conv_tick !== 1'b1);
    do begin @(posedge core_clk); g++; end while (conv_tick !== 1'b1);
  endtask

  // --------
  // Result watcher
  // --------
  always @(posedge core_clk) begin
    rd_q <= reg_rd;
    samp_q <= sampling;
    cyc <= cyc + 1;
    if (sampling) slen <= samp_q ? slen + 1 : 1;
    if (convert_start) convs <= convs + 1;
    if (rd_q) chk("read data", exp_rd.pop_front(), reg_rdata);
    if (sampling && !samp_q && exp_sel.size() > 0)
      chk("input select", exp_sel.pop_front(), {pos_in_lowref, neg_in_sel, pos_in_sel});
    if (cyc == 20000) begin
      failures++;
      report_and_stop;
    end
  end

  // --------
  // Main sequence
  // --------
  initial begin
    sys_rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; go = 1'b0; rd_q = 1'b0; samp_q = 1'b0;
    reg_addr = 5'h0; reg_wdata = 32'h0; hold_cyc = 8'h10;
    n = $urandom(20257);
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    mk = '{32'h9fff, 32'h8f8f0000, 32'hffff, 32'h1f};
    for (int i = 0; i < 4; i++) bus(0, 5'(i * 4), 32'h0);
    for (int i = 0; i < 5; i++) begin
      m = $urandom;
      bus(1, 5'(i < 4 ? i * 4 : 20), m);
      bus(0, 5'(i < 4 ? i * 4 : 20), i < 4 ? m & mk[i] : 32'h0);
    end
    idle;
    $display("registers done");
    for (int i = 0; i < 2; i++) begin
      d = i ? $urandom_range(255, 1) : 0;
      bus(1, 5'h0, d);
      idle;
      tick_gap(n);
      tick_gap(n);
      chk("tick gap", 2 * (d + 1), n);
    end
    for (int i = 0; i < 2; i++) begin
      bus(1, 5'h0, i ? 32'h80ff : 32'h8000);
      idle;
      n = 0;
      repeat (300) begin @(posedge core_clk); n += conv_tick; end
      chk("rc ticks in range", 1, n >= 97 && n <= 103);
    end
    $display("clock done");
    m = $urandom & 32'h8f8f0000;
    if (&m[19:16]) m[16] = 1'b0;
    if (&m[27:24]) m[24] = 1'b0;
    s = $urandom_range(31, 1);
    bus(1, 5'h4, m);
    bus(1, 5'h0, (s << 8) | 1);
    bus(1, 5'hc, 32'h7);
    idle;
    smp(140, {m[23], m[19:16]});
    chk("auto length in range", 1, slen >= 4 * s - 3 && slen <= 4 * s + 2);
    n = convs;
    bus(1, 5'hc, 32'h0);
    idle;
    smp(20, {m[23], m[19:16]});
    chk("convert count", n, convs);
    $display("sampling done");
    bus(1, 5'h0, 32'h101);
    bus(1, 5'hc, 32'hf);
    idle;
    chk("ctrl outputs", 32'hf, {scan_enable, alternate_sample_en, trigger_source_sel});
    for (int i = 0; i < 4; i++) smp(16, i[0] ? {m[31], m[27:24]} : {m[23], m[19:16]});
    $display("alternate done");
    d = $urandom_range(65535, 1) | 32'h400;
    bus(1, 5'h8, d);
    bus(1, 5'hc, 32'h17);
    idle;
    chk("ctrl outputs", 32'h17, {scan_enable, alternate_sample_en, trigger_source_sel});
    for (int i = 0; i < 16; i++) if (d[i]) q.push_back(i);
    for (int i = 0; i < q.size() + 2; i++) begin
      s = q[i % q.size()];
      smp(16, {s >= PINS && s <= 12, m[23], 4'(s)});
    end
    $display("scan done");
    report_and_stop;
  end
endmodule // adcts_top_test
`default_nettype wire
